// [pbc_change_detect.sv]
`timescale 1ns/10ps
`default_nettype none
module pbc_change_detect #(
    parameter int PORT_W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Pins and control
    input wire logic [PORT_W-1:0] pins_i,
    input wire logic [PORT_W-1:0] enable_i,
    input wire logic snap_i,
    input wire logic clear_i,
    // Status
    output logic mismatch_o,
    output logic flag_o
);
    logic [PORT_W-1:0] last_read;
    logic next_flag;

    // A change in the same cycle as a port access is still caught, because the
    // comparison uses the old snapshot before it is replaced.
    assign mismatch_o = |(enable_i & (pins_i ^ last_read)); // RL1 RL16
    assign next_flag = mismatch_o | (flag_o & ~clear_i); // RL17

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_read <= '0;
            flag_o <= 1'b0;
        end else begin
            flag_o <= next_flag;
            if (snap_i) begin
                last_read <= pins_i; // RL17
            end
        end
    end

    property p_mismatch_sets;
        @(posedge clk_i) disable iff (!rst_n_i)
        mismatch_o |=> flag_o;
    endproperty
    a_mismatch_sets: assert property (p_mismatch_sets) // RL16
        else $error("Mismatch did not set the change flag.");

    property p_clear_works;
        @(posedge clk_i) disable iff (!rst_n_i)
        (clear_i && !mismatch_o) |=> !flag_o;
    endproperty
    a_clear_works: assert property (p_clear_works) // RL17
        else $error("Change flag survived a clear without mismatch.");
endmodule // pbc_change_detect
`default_nettype wire

// [pbc_defines.svh]
`ifndef PBC_DEFINES_SVH
`define PBC_DEFINES_SVH
// Behaviour
// RL1: Each port one pin has change-interrupt enable.
// RL2: Analog select turns off digital input buffer.
// RL3: Cleared analog select makes pin digital.
// RL4: Analog select upper two bits read zero.
// RL5: Software sets direction input for analog pins.
// RL6: Port two direction one tri-states the driver.
// RL7: Port two direction zero drives output latch.
// RL8: Port data read returns pins, write latches.
// RL9: Port data writes merge sampled pin levels.
// RL10: Analog pins read as zero.
// RL11: Direction bits control drivers even when analog.
// RL12: One bit routes compare channel two pin.
// RL13: Port one bit zero feeds external interrupt.
// RL14: Port one bit five feeds timer gate.
// RL15: Bits six, seven carry programming clock, data.
// RL16: Enabled pin mismatches set port change flag.
// RL17: Port access ends mismatch; mismatch keeps flag set.
// RL18: Pull-up off whenever pin drives output.
// RL19: Global pull-up disable gates all pull-ups.
// RL20: Registers update on write edge, reset clears; direction, pull-up, analog select and pull-up disable reset to ones.

`define PBC_ADDR_W 4
`define PBC_DATA_W 8

`define PBC_OFS_PB_DATA 4'h0
`define PBC_OFS_PB_DIR 4'h1
`define PBC_OFS_PB_PULLUP 4'h2
`define PBC_OFS_IOC_EN 4'h3
`define PBC_OFS_ANSEL 4'h4
`define PBC_OFS_APF 4'h5
`define PBC_OFS_OPTION 4'h6
`define PBC_OFS_PC_DATA 4'h7
`define PBC_OFS_PC_DIR 4'h8
`define PBC_OFS_STATUS 4'h9
`define PBC_OFS_PB_SET 4'ha
`define PBC_OFS_PB_CLR 4'hb
`define PBC_OFS_PC_SET 4'hc
`define PBC_OFS_PC_CLR 4'hd

`define PBC_RST_DIR 8'hff
`define PBC_RST_PULLUP 8'hff
`define PBC_RST_IOC 8'h00
`define PBC_RST_ANSEL 6'h3f
`define PBC_RST_APF_SEL 1'b0
`define PBC_RST_PUDIS 1'b1
`define PBC_RST_LATCH 8'h00

`define PBC_APF_CMP2_BIT 0
`define PBC_OPT_PUDIS_BIT 7
`define PBC_STAT_FLAG_BIT 0

`define PBC_PB_EXT_INT_BIT 0
`define PBC_PB_CMP2_BIT 3
`define PBC_PB_TGATE_BIT 5
`define PBC_PB_PCLK_BIT 6
`define PBC_PB_PDATA_BIT 7
`define PBC_PC_CMP2_BIT 1
`endif

// [pbc_pin_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Pin model for both ports, packed side by side
// ----------------------------------------------------------------------
module pbc_pin_model #(
    parameter int W = 16
) (
    // Clock
    input wire logic clk_i,
    // Device side
    input wire logic [W-1:0] out_i,
    input wire logic [W-1:0] oe_i,
    input wire logic [W-1:0] pullup_i,
    // Outside driver
    input wire logic [W-1:0] ext_i,
    input wire logic [W-1:0] ext_en_i,
    // Resolved levels
    output logic [W-1:0] pin_o
);
    logic [W-1:0] last = '0;
    logic [W-1:0] driven;
    logic [W-1:0] floating;
    // The device driver wins over the outside driver.
    assign driven = (oe_i & out_i) | (~oe_i & ext_en_i & ext_i);
    // An undriven pin without pull-up flips every cycle, so a stale value never passes.
    assign floating = ~oe_i & ~ext_en_i & (pullup_i | ~last);
    assign pin_o = driven | floating;
    always_ff @(posedge clk_i) begin
        last <= pin_o;
    end
endmodule // pbc_pin_model
`default_nettype wire

// [pbc_pkg.sv]
`default_nettype none
`include "pbc_defines.svh"
package pbc_pkg;
    typedef struct packed {
        logic [`PBC_ADDR_W-1:0] addr;
        logic [`PBC_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } pbc_bus_req_t;

    typedef struct packed {
        logic [`PBC_DATA_W-1:0] out;
        logic [`PBC_DATA_W-1:0] oe;
    } pbc_pin_drive_t;
endpackage
`default_nettype wire

// [pbc_port_ctrl.sv]
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "pbc_defines.svh"
module pbc_port_ctrl
    import pbc_pkg::*;
#(
    parameter int PORT_W = 8,
    parameter int ANALOG_PINS = 6
) (
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    // Register port
    input wire pbc_bus_req_t BUS_REQ_I,
    output logic [PORT_W-1:0] RDATA_O,
    // Port one pins
    input wire logic [PORT_W-1:0] PB_IN_I,
    output logic [PORT_W-1:0] PB_OUT_O,
    output logic [PORT_W-1:0] PB_OE_O,
    output logic [PORT_W-1:0] PB_PULLUP_O,
    output logic [PORT_W-1:0] PB_INBUF_EN_O,
    // Port two pins
    input wire logic [PORT_W-1:0] PC_IN_I,
    output logic [PORT_W-1:0] PC_OUT_O,
    output logic [PORT_W-1:0] PC_OE_O,
    // Compare channel two
    input wire logic CMP2_OUT_I,
    input wire logic CMP2_OUT_EN_I,
    output logic CMP2_IN_O,
    // Other alternate functions
    output logic EXT_INT_O,
    output logic TIMER_GATE_O,
    input wire logic PROG_MODE_I,
    input wire logic PROG_DATA_OUT_I,
    input wire logic PROG_DATA_OE_I,
    output logic PROG_CLK_O,
    output logic PROG_DATA_O,
    // Change status
    output logic PORT_CHANGE_FLAG_O
);
    if (PORT_W != `PBC_DATA_W || ANALOG_PINS < 1 || ANALOG_PINS > PORT_W - 2) begin : g_bad
        $error("Unsupported port width or analog pin count.");
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic is_at(input logic [`PBC_ADDR_W-1:0] addr,
                                   input logic [`PBC_ADDR_W-1:0] ofs);
        return addr == ofs;
    endfunction

    function automatic logic [PORT_W-1:0] merge(input logic [PORT_W-1:0] pins,
                                                input logic [PORT_W-1:0] mask,
                                                input logic set);
        return set ? (pins | mask) : (pins & ~mask);
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [PORT_W-1:0] pb_latch;
    logic [PORT_W-1:0] pb_dir;
    logic [PORT_W-1:0] pb_pullup_en;
    logic [PORT_W-1:0] change_irq_enable;
    logic [ANALOG_PINS-1:0] analog_pin_select;
    logic compare_two_pin_select;
    logic global_pullup_disable;
    logic [PORT_W-1:0] pc_latch;
    logic [PORT_W-1:0] pc_dir;
    logic mismatch;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire logic [`PBC_ADDR_W-1:0] addr = BUS_REQ_I.addr;
    wire logic [PORT_W-1:0] wdata = BUS_REQ_I.wdata;
    wire logic hit_pb_data = is_at(addr, `PBC_OFS_PB_DATA);
    wire logic hit_pb_dir = is_at(addr, `PBC_OFS_PB_DIR);
    wire logic hit_pb_pullup = is_at(addr, `PBC_OFS_PB_PULLUP);
    wire logic hit_ioc = is_at(addr, `PBC_OFS_IOC_EN);
    wire logic hit_ansel = is_at(addr, `PBC_OFS_ANSEL);
    wire logic hit_apf = is_at(addr, `PBC_OFS_APF);
    wire logic hit_option = is_at(addr, `PBC_OFS_OPTION);
    wire logic hit_pc_data = is_at(addr, `PBC_OFS_PC_DATA);
    wire logic hit_pc_dir = is_at(addr, `PBC_OFS_PC_DIR);
    wire logic hit_status = is_at(addr, `PBC_OFS_STATUS);
    wire logic hit_pb_set = is_at(addr, `PBC_OFS_PB_SET);
    wire logic hit_pb_clr = is_at(addr, `PBC_OFS_PB_CLR);
    wire logic hit_pc_set = is_at(addr, `PBC_OFS_PC_SET);
    wire logic hit_pc_clr = is_at(addr, `PBC_OFS_PC_CLR);
    wire logic wr = BUS_REQ_I.wr;
    wire logic pb_access = (BUS_REQ_I.rd | wr) & (hit_pb_data | hit_pb_set | hit_pb_clr);

    // Analog pins see a dead input buffer, so they read and compare as zero.
    wire logic [PORT_W-1:0] analog_mask = PORT_W'(analog_pin_select);
    wire logic [PORT_W-1:0] pb_dig = PB_IN_I & ~analog_mask; // RL2 RL3 RL10

    // A full write modifies every bit, so the merge leaves only the written
    // value; set and clear writes keep the sampled levels of the other bits.
    // An output pin held by an external load can thus flip its latch bit.
    wire logic [PORT_W-1:0] next_pb_latch =
        (wr && hit_pb_data) ? wdata :
        (wr && hit_pb_set) ? merge(pb_dig, wdata, 1'b1) : // RL9
        (wr && hit_pb_clr) ? merge(pb_dig, wdata, 1'b0) : pb_latch; // RL9
    wire logic [PORT_W-1:0] next_pc_latch =
        (wr && hit_pc_data) ? wdata :
        (wr && hit_pc_set) ? merge(PC_IN_I, wdata, 1'b1) : // RL9
        (wr && hit_pc_clr) ? merge(PC_IN_I, wdata, 1'b0) : pc_latch; // RL9

    wire logic flag_clear = wr & hit_status & ~wdata[`PBC_STAT_FLAG_BIT];

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [PORT_W-1:0] next_rdata;
    always_comb begin
        next_rdata = '0;
        if (hit_pb_data) begin
            next_rdata = pb_dig; // RL8 RL10
        end else if (hit_pb_dir) begin
            next_rdata = pb_dir;
        end else if (hit_pb_pullup) begin
            next_rdata = pb_pullup_en;
        end else if (hit_ioc) begin
            next_rdata = change_irq_enable;
        end else if (hit_ansel) begin
            next_rdata = analog_mask; // RL4
        end else if (hit_apf) begin
            next_rdata[`PBC_APF_CMP2_BIT] = compare_two_pin_select;
        end else if (hit_option) begin
            next_rdata[`PBC_OPT_PUDIS_BIT] = global_pullup_disable;
        end else if (hit_pc_data) begin
            next_rdata = PC_IN_I; // RL8
        end else if (hit_pc_dir) begin
            next_rdata = pc_dir;
        end else if (hit_status) begin
            next_rdata[`PBC_STAT_FLAG_BIT] = PORT_CHANGE_FLAG_O;
        end
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    pbc_pin_drive_t next_pb;
    pbc_pin_drive_t next_pc;
    always_comb begin
        next_pb.oe = ~pb_dir; // RL11
        next_pb.out = pb_latch;
        if (!compare_two_pin_select && CMP2_OUT_EN_I) begin
            next_pb.out[`PBC_PB_CMP2_BIT] = CMP2_OUT_I; // RL12
        end
        if (PROG_MODE_I) begin
            next_pb.oe[`PBC_PB_PCLK_BIT] = 1'b0; // RL15
            next_pb.oe[`PBC_PB_PDATA_BIT] = PROG_DATA_OE_I; // RL15
            next_pb.out[`PBC_PB_PDATA_BIT] = PROG_DATA_OUT_I; // RL15
        end
        next_pc.oe = ~pc_dir; // RL6 RL7
        next_pc.out = pc_latch; // RL7
        if (compare_two_pin_select && CMP2_OUT_EN_I) begin
            next_pc.out[`PBC_PC_CMP2_BIT] = CMP2_OUT_I; // RL12
        end
    end

    wire logic [PORT_W-1:0] next_pullup =
        pb_pullup_en & ~next_pb.oe & {PORT_W{~global_pullup_disable}}; // RL18 RL19
    wire logic next_cmp2_in = compare_two_pin_select ? PC_IN_I[`PBC_PC_CMP2_BIT]
                                                     : pb_dig[`PBC_PB_CMP2_BIT]; // RL12

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pb_latch <= `PBC_RST_LATCH;
            pb_dir <= `PBC_RST_DIR;
            pb_pullup_en <= `PBC_RST_PULLUP;
            change_irq_enable <= `PBC_RST_IOC;
            analog_pin_select <= `PBC_RST_ANSEL;
            compare_two_pin_select <= `PBC_RST_APF_SEL;
            global_pullup_disable <= `PBC_RST_PUDIS;
            pc_latch <= `PBC_RST_LATCH;
            pc_dir <= `PBC_RST_DIR;
        end else begin
            pb_latch <= next_pb_latch; // RL8 RL20
            pc_latch <= next_pc_latch; // RL8 RL20
            if (wr && hit_pb_dir) pb_dir <= wdata; // RL20
            if (wr && hit_pb_pullup) pb_pullup_en <= wdata; // RL20
            if (wr && hit_ioc) change_irq_enable <= wdata; // RL1 RL20
            if (wr && hit_ansel) analog_pin_select <= wdata[ANALOG_PINS-1:0]; // RL4 RL20
            if (wr && hit_apf) compare_two_pin_select <= wdata[`PBC_APF_CMP2_BIT]; // RL20
            if (wr && hit_option) global_pullup_disable <= wdata[`PBC_OPT_PUDIS_BIT]; // RL20
            if (wr && hit_pc_dir) pc_dir <= wdata; // RL20
        end
    end

    // Read data stand for exactly one cycle after the read strobe.
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RDATA_O <= '0;
        end else begin
            RDATA_O <= BUS_REQ_I.rd ? next_rdata : '0;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            PB_OUT_O <= '0;
            PB_OE_O <= '0;
            PB_PULLUP_O <= '0;
            PB_INBUF_EN_O <= '0;
            PC_OUT_O <= '0;
            PC_OE_O <= '0;
            CMP2_IN_O <= 1'b0;
            EXT_INT_O <= 1'b0;
            TIMER_GATE_O <= 1'b0;
            PROG_CLK_O <= 1'b0;
            PROG_DATA_O <= 1'b0;
        end else begin
            PB_OUT_O <= next_pb.out;
            PB_OE_O <= next_pb.oe; // RL11
            PB_PULLUP_O <= next_pullup; // RL18 RL19
            PB_INBUF_EN_O <= ~analog_mask; // RL2 RL3
            PC_OUT_O <= next_pc.out; // RL7
            PC_OE_O <= next_pc.oe; // RL6
            CMP2_IN_O <= next_cmp2_in; // RL12
            EXT_INT_O <= pb_dig[`PBC_PB_EXT_INT_BIT]; // RL13
            TIMER_GATE_O <= pb_dig[`PBC_PB_TGATE_BIT]; // RL14
            PROG_CLK_O <= pb_dig[`PBC_PB_PCLK_BIT]; // RL15
            PROG_DATA_O <= pb_dig[`PBC_PB_PDATA_BIT]; // RL15
        end
    end

    pbc_change_detect #(
        .PORT_W(PORT_W)
    ) u_change (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RST_N_I),
        .pins_i(pb_dig),
        .enable_i(change_irq_enable),
        .snap_i(pb_access), // RL17
        .clear_i(flag_clear),
        .mismatch_o(mismatch),
        .flag_o(PORT_CHANGE_FLAG_O)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_ansel_top_zero;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (BUS_REQ_I.rd && hit_ansel) |=> (RDATA_O[7:6] == 2'b00);
    endproperty
    a_ansel_top_zero: assert property (p_ansel_top_zero) // RL4
        else $error("Analog select upper bits read nonzero.");

    property p_inbuf;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        RST_N_I |=> (PB_INBUF_EN_O == ~$past(analog_mask));
    endproperty
    a_inbuf: assert property (p_inbuf) // RL2
        else $error("Input buffer enable disagrees with analog select.");

    property p_pc_oe;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        RST_N_I |=> (PC_OE_O == ~$past(pc_dir));
    endproperty
    a_pc_oe: assert property (p_pc_oe) // RL6
        else $error("Port two driver enable disagrees with direction.");

    property p_pc_read;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (BUS_REQ_I.rd && hit_pc_data) |=> (RDATA_O == $past(PC_IN_I));
    endproperty
    a_pc_read: assert property (p_pc_read) // RL8
        else $error("Port two read did not return pin levels.");

    property p_rmw_set;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (wr && hit_pb_set) |=> (pb_latch == ($past(pb_dig) | $past(wdata)));
    endproperty
    a_rmw_set: assert property (p_rmw_set) // RL9
        else $error("Set write did not merge sampled pins.");

    property p_analog_read_zero;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (BUS_REQ_I.rd && hit_pb_data) |=> ((RDATA_O & $past(analog_mask)) == '0);
    endproperty
    a_analog_read_zero: assert property (p_analog_read_zero) // RL10
        else $error("Analog pin read as one.");

    property p_pullup_off_out;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        1'b1 |-> ((PB_PULLUP_O & PB_OE_O) == '0);
    endproperty
    a_pullup_off_out: assert property (p_pullup_off_out) // RL18
        else $error("Pull-up active on a driven pin.");

    property p_global_pullup;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        global_pullup_disable |=> (PB_PULLUP_O == '0);
    endproperty
    a_global_pullup: assert property (p_global_pullup) // RL19
        else $error("Pull-up active while globally disabled.");

    property p_cmp2_route;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        $past(compare_two_pin_select) |-> (CMP2_IN_O == $past(PC_IN_I[1]));
    endproperty
    a_cmp2_route: assert property (p_cmp2_route) // RL12
        else $error("Compare input not taken from port two.");

    property p_ext_int;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        RST_N_I |=> (EXT_INT_O == $past(pb_dig[0]));
    endproperty
    a_ext_int: assert property (p_ext_int) // RL13
        else $error("External interrupt line does not follow bit zero.");

    property p_dir_write;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (wr && hit_pb_dir) |=> (pb_dir == $past(wdata)) ##1 (PB_OE_O == ~pb_dir ||
                                                              PROG_MODE_I);
    endproperty
    a_dir_write: assert property (p_dir_write) // RL20
        else $error("Direction write did not take effect.");

    property p_access_ends;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        pb_access ##1 ($stable(pb_dig) && $stable(change_irq_enable)) |-> !mismatch;
    endproperty
    a_access_ends: assert property (p_access_ends) // RL17
        else $error("Port access did not end the mismatch.");
endmodule // pbc_port_ctrl
`default_nettype wire

// [testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench
    import pbc_pkg::*;
;
    typedef struct packed {
        logic wr;
        logic [3:0] a;
        logic [7:0] d;
        logic [7:0] e;
        logic [7:0] m;
    } pbc_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    pbc_bus_req_t bus = '0;
    logic [7:0] rdata, pb_out, pb_oe, pb_pu, pb_ib, pc_out, pc_oe, rv;
    logic cmp_out = 1'b0, cmp_en = 1'b0;
    logic prog_mode = 1'b0, prog_dout = 1'b0, prog_doe = 1'b0;
    logic cmp_in, ext_int, tgate, pclk, pdata, flag;
    logic [15:0] ext = '0;
    logic [15:0] ext_en = 16'hffff;
    wire logic [15:0] pins;
    int errors = 0;
    int check_count = 0;
    pbc_row_t rows [0:19] = '{
        '{1'b0, 4'h1, 8'h00, 8'hff, 8'hff}, '{1'b0, 4'h2, 8'h00, 8'hff, 8'hff},
        '{1'b0, 4'h3, 8'h00, 8'h00, 8'hff}, '{1'b0, 4'h4, 8'h00, 8'h3f, 8'hff},
        '{1'b0, 4'h5, 8'h00, 8'h00, 8'h01}, '{1'b0, 4'h6, 8'h00, 8'h80, 8'h80},
        '{1'b0, 4'h8, 8'h00, 8'hff, 8'hff}, '{1'b0, 4'h9, 8'h00, 8'h00, 8'h01},
        '{1'b0, 4'hf, 8'h00, 8'h00, 8'hff}, '{1'b1, 4'h4, 8'hff, 8'h00, 8'h00},
        '{1'b0, 4'h4, 8'h00, 8'h3f, 8'hff}, '{1'b1, 4'h3, 8'ha5, 8'h00, 8'h00},
        '{1'b0, 4'h3, 8'h00, 8'ha5, 8'hff}, '{1'b1, 4'h2, 8'h3c, 8'h00, 8'h00},
        '{1'b0, 4'h2, 8'h00, 8'h3c, 8'hff}, '{1'b1, 4'h2, 8'hff, 8'h00, 8'h00},
        '{1'b1, 4'hf, 8'h55, 8'h00, 8'h00}, '{1'b0, 4'hf, 8'h00, 8'h00, 8'hff},
        '{1'b0, 4'ha, 8'h00, 8'h00, 8'hff}, '{1'b1, 4'h3, 8'h00, 8'h00, 8'h00}};

    always #10 clk = ~clk;

    pbc_port_ctrl i_pbc_port_ctrl (
        .CORE_CLK_I(clk), .RST_N_I(rst_n), .BUS_REQ_I(bus), .RDATA_O(rdata),
        .PB_IN_I(pins[7:0]), .PB_OUT_O(pb_out), .PB_OE_O(pb_oe), .PB_PULLUP_O(pb_pu),
        .PB_INBUF_EN_O(pb_ib), .PC_IN_I(pins[15:8]), .PC_OUT_O(pc_out), .PC_OE_O(pc_oe),
        .CMP2_OUT_I(cmp_out), .CMP2_OUT_EN_I(cmp_en), .CMP2_IN_O(cmp_in),
        .EXT_INT_O(ext_int), .TIMER_GATE_O(tgate), .PROG_MODE_I(prog_mode),
        .PROG_DATA_OUT_I(prog_dout), .PROG_DATA_OE_I(prog_doe), .PROG_CLK_O(pclk),
        .PROG_DATA_O(pdata), .PORT_CHANGE_FLAG_O(flag)
    );
    pbc_pin_model i_pbc_pin_model (
        .clk_i(clk), .out_i({pc_out, pb_out}), .oe_i({pc_oe, pb_oe}),
        .pullup_i({8'h00, pb_pu}), .ext_i(ext), .ext_en_i(ext_en), .pin_o(pins)
    );

    // ------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
        rv = rdata;
        chk("rdata", e, rv & m);
    endtask
    // Outputs trail a register write by two edges; three leaves margin.
    task automatic settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic stop_test;
        $display("Checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        stop_test;
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr_reg(rows[i].a, rows[i].d);
            end else begin
                rd_chk(rows[i].a, rows[i].e, rows[i].m);
            end
        end
        ext <= 16'hc300;
        wr_reg(4'h7, 8'h5a);
        wr_reg(4'h8, 8'hf0);
        settle;
        chk("pc_oe", 8'h0f, pc_oe);
        chk("pc_out", 8'h0a, pc_out & pc_oe);
        rd_chk(4'h7, 8'hca, 8'hff);
        wr_reg(4'hc, 8'h01);
        settle;
        chk("pc_out", 8'h0b, pc_out & pc_oe);
        wr_reg(4'hd, 8'h80);
        wr_reg(4'h8, 8'h00);
        settle;
        chk("pc_out", 8'h4b, pc_out);
        wr_reg(4'h8, 8'hff);
        // Analog pins keep their direction set to input here.
        ext <= 16'hc3a1;
        rd_chk(4'h0, 8'h80, 8'hff);
        chk("pb_inbuf", 8'hc0, pb_ib);
        chk("ext_int", 8'h00, {7'h0, ext_int});
        wr_reg(4'h4, 8'h00);
        settle;
        chk("pb_inbuf", 8'hff, pb_ib);
        rd_chk(4'h0, 8'ha1, 8'hff);
        chk("alt_fn", 8'h0b, {4'h0, pdata, pclk, tgate, ext_int});
        wr_reg(4'h6, 8'h00);
        settle;
        chk("pb_pu", 8'hff, pb_pu);
        wr_reg(4'h4, 8'h3f);
        wr_reg(4'h1, 8'hf0);
        settle;
        chk("pb_oe", 8'h0f, pb_oe);
        chk("pb_pu", 8'hf0, pb_pu);
        wr_reg(4'h6, 8'h80);
        settle;
        chk("pb_pu", 8'h00, pb_pu);
        wr_reg(4'h4, 8'h00);
        wr_reg(4'ha, 8'h05);
        settle;
        chk("pb_out", 8'ha5, pb_out);
        wr_reg(4'hb, 8'h81);
        settle;
        chk("pb_out", 8'h24, pb_out);
        wr_reg(4'h1, 8'hf7);
        cmp_en <= 1'b1;
        cmp_out <= 1'b1;
        settle;
        chk("pb_out3", 8'h01, {7'h0, pb_out[3]});
        chk("cmp_in", 8'h01, {7'h0, cmp_in});
        wr_reg(4'h5, 8'h01);
        cmp_out <= 1'b0;
        settle;
        chk("cmp_in", 8'h01, {7'h0, cmp_in});
        wr_reg(4'h8, 8'hfd);
        settle;
        chk("pc_out1", 8'h00, {7'h0, pc_out[1]});
        chk("pb_out3", 8'h00, {7'h0, pb_out[3]});
        wr_reg(4'h8, 8'hff);
        wr_reg(4'h5, 8'h00);
        cmp_en <= 1'b0;
        wr_reg(4'h1, 8'hff);
        wr_reg(4'h3, 8'h01);
        rd_chk(4'h0, 8'ha1, 8'hff);
        @(posedge clk);
        ext <= 16'hc3a3;
        settle;
        chk("flag", 8'h00, {7'h0, flag});
        @(posedge clk);
        ext <= 16'hc3a2;
        settle;
        chk("flag", 8'h01, {7'h0, flag});
        wr_reg(4'h9, 8'h00);
        settle;
        chk("flag", 8'h01, {7'h0, flag});
        rd_chk(4'h0, 8'ha2, 8'hff);
        wr_reg(4'h9, 8'h00);
        settle;
        chk("flag", 8'h00, {7'h0, flag});
        wr_reg(4'h1, 8'h3f);
        prog_mode <= 1'b1;
        prog_doe <= 1'b1;
        prog_dout <= 1'b1;
        settle;
        chk("pb_oe76", 8'h02, {6'h0, pb_oe[7:6]});
        chk("pb_out7", 8'h01, {7'h0, pb_out[7]});
        @(posedge clk);
        prog_mode <= 1'b0;
        rst_n <= 1'b0;
        @(negedge clk);
        chk("rst_outs", 8'h00, pb_oe | pb_pu | pb_ib | pc_oe);
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk("pb_inbuf", 8'hc0, pb_ib);
        chk("oe_pu", 8'h00, pb_oe | pc_oe | pb_pu);
        rd_chk(4'h1, 8'hff, 8'hff);
        rd_chk(4'h3, 8'h00, 8'hff);
        stop_test;
    end
endmodule // testbench
`default_nettype wire
